/* edge_evt_if.sv */
// Purpose: Carries synchronised levels and edge pulses between blocks
// Assumes: Driven by edge_sampler, read by the aggregator
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface edge_evt_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : edge_evt_if
`default_nettype wire

/* edge_sampler.sv */
// Purpose: Two-stage synchroniser plus edge detector per input bit
// Assumes: Raw inputs may change at any time
// Notes:   Edges compare the second stage against a third sample
`timescale 1ns/1ps
`default_nettype none
module edge_sampler #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw_in,
  edge_evt_if.src           ev
);

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      logic prev_reg;

      always_ff @(posedge clk) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          prev_reg <= 1'b0;
        end else begin
          meta_reg <= raw_in[i];
          sync_reg <= meta_reg;
          prev_reg <= sync_reg;
        end
      end

      assign ev.level[i] = sync_reg;
      assign ev.rise[i]  = sync_reg & ~prev_reg; // RULE25
      assign ev.fall[i]  = ~sync_reg & prev_reg; // RULE25
    end
  endgenerate

endmodule : edge_sampler
`default_nettype wire

/* gpio_edge_mgmt_irq_aggregator_test.sv */
// Purpose: Self-checking bench for the management interrupt aggregator
// Assumes: Inputs change on the falling edge; settle waits cover latency
// Notes:   Expected values queue up and a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module gpio_edge_mgmt_irq_aggregator_test;
  logic       clk, rst, status2_read, shared_pin_irq_select, pin_ctrl_write;
  logic       device_irq_wake_enable, host_active_high;
  logic [2:0] edge_pin_in, edge_polarity, dual_edge_trigger, edge_wake_enable;
  logic [2:0] edge_mgmt_enable, edge_wake_clear, edge_mgmt_clear, edge_group_clear;
  logic [2:0] misc_clear, edge_data_status, edge_wake_status, edge_mgmt_status;
  logic [2:0] wake_status_reg_group, misc_edge_status_reg;
  logic [7:0] gp_event_in, gp_polarity, gp_mgmt_enable, gp_mgmt_clear, gp_mgmt_status;
  logic [6:0] periph_event, periph_enable, mgmt_irq_status_reg_second;
  logic [7:0] mgmt_enable_second, pin_ctrl_wdata, pin_ctrl_reg, wake_status_reg_third;
  logic       edge_wake_request, group_mgmt_irq_internal, group_mgmt_irq_pin_out;
  logic       group_mgmt_irq_pin_oe, serial_irq2_request, device_irq_wake_request;
  logic       pin_level, irq_seen;
  logic [15:0] notes[$];
  logic [15:0] n;
  logic [7:0]  got, m;
  int          fail_count, num_checks, cycles, i, p, k, seed;
  event        look;

  mgmt_irq_aggregator #(.N_EDGE(3), .N_GP(8)) i_dut (
    .clk, .rst, .edge_pin_in, .edge_polarity, .dual_edge_trigger, .edge_wake_enable,
    .edge_mgmt_enable, .edge_wake_clear, .edge_mgmt_clear, .edge_group_clear,
    .misc_clear, .edge_data_status, .edge_wake_status, .edge_mgmt_status,
    .wake_status_reg_group, .misc_edge_status_reg, .edge_wake_request,
    .gp_event_in, .gp_polarity, .gp_mgmt_enable, .gp_mgmt_clear, .gp_mgmt_status,
    .periph_event, .periph_enable, .status2_read, .mgmt_irq_status_reg_second,
    .mgmt_enable_second, .shared_pin_irq_select, .pin_ctrl_write, .pin_ctrl_wdata,
    .pin_ctrl_reg, .device_irq_wake_enable, .group_mgmt_irq_internal,
    .group_mgmt_irq_pin_out, .group_mgmt_irq_pin_oe, .serial_irq2_request,
    .wake_status_reg_third, .device_irq_wake_request);

  mgmt_host_model i_host (.pin_out(group_mgmt_irq_pin_out),
    .pin_oe(group_mgmt_irq_pin_oe), .active_high(host_active_high),
    .pin_level(pin_level), .irq_seen(irq_seen));

  // --------------------------------------------------------------
  // Clock, timeout and closing
  // --------------------------------------------------------------
  initial clk = 1'h0;
  always #25 clk = ~clk;

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD t=%0t timeout", $time);
      final_report();
    end
  end

  // --------------------------------------------------------------
  // Monitor: oldest note against the selected output
  // --------------------------------------------------------------
  function automatic logic [7:0] obs(input logic [7:0] sel);
    case (sel)
      0: obs = {5'h0, edge_wake_status};
      1: obs = {5'h0, edge_mgmt_status};
      2: obs = {5'h0, wake_status_reg_group};
      3: obs = {5'h0, misc_edge_status_reg};
      4: obs = {5'h0, edge_data_status};
      5: obs = gp_mgmt_status;
      6: obs = {1'h0, mgmt_irq_status_reg_second};
      7: obs = {7'h0, group_mgmt_irq_internal};
      8: obs = {7'h0, irq_seen};
      9: obs = {7'h0, serial_irq2_request};
      10: obs = wake_status_reg_third;
      11: obs = {7'h0, device_irq_wake_request};
      12: obs = {7'h0, edge_wake_request};
      13: obs = pin_ctrl_reg;
      default: obs = {7'h0, group_mgmt_irq_pin_oe};
    endcase
  endfunction : obs

  always @(look) begin
    n = notes.pop_front();
    got = obs(n[15:8]);
    num_checks++;
    if (got !== n[7:0]) begin
      fail_count++;
      $display("BAD t=%0t sel=%0d exp=%h got=%h", $time, n[15:8], n[7:0], got);
    end
  end

  task automatic chk(input int sel, input logic [7:0] exp);
    notes.push_back({sel[7:0], exp});
    -> look;
    #1;
  endtask : chk

  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask : step

  task automatic clr_all();
    {edge_wake_clear, edge_mgmt_clear, edge_group_clear, misc_clear} = 12'hfff;
    gp_mgmt_clear = 8'hff;
    step(1);
    {edge_wake_clear, edge_mgmt_clear, edge_group_clear, misc_clear} = 12'h000;
    gp_mgmt_clear = 8'h00;
    step(1);
  endtask : clr_all

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 65;
    rst = 1'h1;
    {status2_read, shared_pin_irq_select, pin_ctrl_write, device_irq_wake_enable} = 4'h0;
    {edge_pin_in, edge_polarity, dual_edge_trigger, edge_wake_enable} = 12'h000;
    {edge_mgmt_enable, edge_wake_clear, edge_mgmt_clear, edge_group_clear} = 12'h000;
    {misc_clear, gp_event_in, gp_polarity, gp_mgmt_enable, gp_mgmt_clear} = 35'h0;
    {periph_event, periph_enable, mgmt_enable_second, pin_ctrl_wdata} = 30'h0;
    host_active_high = 1'h0;
    step(2);
    rst = 1'h0;
    step(1);
    chk(13, 8'h00);
    chk(7, 8'h00);
    $display("test reset done");
    // Dual-edge pin 0 with inverted polarity: both edges count
    {edge_wake_enable, edge_mgmt_enable, dual_edge_trigger, edge_polarity} = 12'hff9;
    edge_pin_in = 3'h1;
    step(7);
    chk(0, 8'h01);
    chk(1, 8'h01);
    chk(2, 8'h01);
    chk(3, 8'h01);
    chk(12, 8'h01);
    chk(7, 8'h01);
    chk(4, 8'h00);
    clr_all();
    chk(3, 8'h00);
    chk(12, 8'h00);
    // Mgmt enable off: status still sets, no group interrupt
    edge_mgmt_enable = 3'h0;
    edge_pin_in = 3'h0;
    step(7);
    chk(7, 8'h00);
    chk(1, 8'h01);
    chk(2, 8'h01);
    chk(4, 8'h01);
    clr_all();
    $display("test dual edge done");
    // Pin 1 without dual-edge: status still set, no request
    edge_polarity = 3'h0;
    dual_edge_trigger = 3'h0;
    edge_pin_in = 3'h2;
    step(7);
    chk(2, 8'h02);
    chk(1, 8'h02);
    chk(12, 8'h00);
    chk(7, 8'h00);
    clr_all();
    edge_pin_in = 3'h0;
    step(7);
    chk(3, 8'h02);
    chk(1, 8'h00);
    clr_all();
    $display("test single edge done");
    // GPIO events with both polarities on a random bit
    for (p = 0; p < 2; p++) begin
      k = $random(seed) & 7;
      m = 8'h01 << k;
      gp_polarity = p[0] ? 8'hff : 8'h00;
      gp_event_in = m;
      step(7);
      chk(5, p[0] ? 8'h00 : m);
      chk(7, 8'h00);
      gp_mgmt_enable = 8'hff;
      step(3);
      chk(7, {7'h0, ~p[0]});
      gp_event_in = 8'h00;
      step(7);
      chk(5, m);
      clr_all();
      chk(5, 8'h00);
      gp_mgmt_enable = 8'h00;
      step(2);
    end
    $display("test gpio done");
    // Peripheral sources one by one
    for (i = 0; i < 7; i++) begin
      periph_event = 7'h01 << i;
      step(3);
      chk(6, {1'h0, periph_event});
      chk(7, 8'h00);
      periph_enable = 7'h01 << i;
      step(3);
      chk(7, 8'h01);
      periph_event = 7'h00;
      step(3);
      chk(6, (i == 4) ? 8'h10 : 8'h00);
      status2_read = 1'h1;
      step(1);
      status2_read = 1'h0;
      step(2);
      chk(6, 8'h00);
      periph_enable = 7'h00;
    end
    $display("test peripherals done");
    // Routing of the group interrupt
    {periph_event, periph_enable} = 14'h0081;
    {shared_pin_irq_select, device_irq_wake_enable} = 2'h3;
    for (i = 0; i < 4; i++) begin
      mgmt_enable_second = (i == 0) ? 8'h00 : (8'h80 >> (i - 1));
      step(4);
      chk(14, {7'h0, i == 1});
      chk(8, {7'h0, i == 1});
      chk(9, {7'h0, i == 2});
      chk(10, (i == 3) ? 8'h08 : 8'h00);
      chk(11, {7'h0, i == 3});
    end
    // Push-pull, active high
    mgmt_enable_second = 8'h80;
    pin_ctrl_wdata = 8'h82;
    pin_ctrl_write = 1'h1;
    step(1);
    pin_ctrl_write = 1'h0;
    host_active_high = 1'h1;
    step(3);
    chk(13, 8'h82);
    chk(8, 8'h01);
    periph_event = 7'h00;
    step(4);
    chk(14, 8'h01);
    chk(8, 8'h00);
    $display("test routing done");
    step(2);
    final_report();
  end
endmodule : gpio_edge_mgmt_irq_aggregator_test
`default_nettype wire

/* mgmt_host_model.sv */
// Purpose: Host chipset side that watches the group interrupt pin
// Assumes: Board pull-up on the pin; active level known to the host
// Notes:   A released pin floats to the pull-up level
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic active_high,
  output logic      pin_level,
  output logic      irq_seen
);
  // --------------------------------------------------------------
  // Wire level and host view
  // --------------------------------------------------------------
  assign pin_level = pin_oe ? pin_out : 1'h1;
  assign irq_seen  = (pin_level === active_high);
endmodule : mgmt_host_model
`default_nettype wire

/* mgmt_irq_aggregator.sv */
// Purpose: Gathers edge, GPIO and peripheral events into one group interrupt
// Assumes: Register writes arrive as one-cycle clear pulses and config levels
// Notes:   Routes the group interrupt to a pin, serial IRQ2 and wake logic
// Operation
// RULE1: Edge pins fire on both transitions
// RULE2: Dual-edge ignores direction, polarity, driver type
// RULE3: Polarity still inverts the data status bit
// RULE4: Dual-edge interrupt needs selection and enable
// RULE5: Any transition sets sticky wake/mgmt status (code: with dual-edge off, only the polarity-selected edge sets them)
// RULE6: Wake group status set, write-one clears
// RULE7: Misc register collects all edge statuses
// RULE8: Status updates regardless of enable or selection
// RULE9: Pin level follows polarity, driver follows bit7
// RULE10: Pin resets to active-low open drain
// RULE11: Group interrupt ORs all enabled events
// RULE12: Enable2 bit7 routes group onto pin
// RULE13: Enable2 bit6 routes group onto IRQ2
// RULE14: Enable2 bit5 routes group into wake
// RULE15: Peripheral sources each gated by enable
// RULE16: GPIO status edge follows polarity setting
// RULE17: Dual-edge GPIO sets on both edges
// RULE18: Latched GPIO status ANDed with enable
// RULE19: Peripheral status follows source, writes ignored
// RULE20: Infrared status cleared by status-2 read
// RULE21: Live peripheral events ANDed with enable
// RULE22: Registers decoded from runtime block base
// RULE23: Device interrupt status at wake3 bit3
// RULE24: Device interrupt enable at wake3 bit3
// RULE25: Inputs synchronised, edges from consecutive samples
`timescale 1ns/1ps
`default_nettype none
module mgmt_irq_aggregator #(
  parameter int N_EDGE = mgmt_irq_pkg::EDGE_PINS_DEFAULT,
  parameter int N_GP   = mgmt_irq_pkg::GP_EVENTS_DEFAULT
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  // Dual-edge capable pins
  input  wire logic [N_EDGE-1:0]                    edge_pin_in,
  input  wire logic [N_EDGE-1:0]                    edge_polarity,
  input  wire logic [N_EDGE-1:0]                    dual_edge_trigger,
  input  wire logic [N_EDGE-1:0]                    edge_wake_enable,
  input  wire logic [N_EDGE-1:0]                    edge_mgmt_enable,
  input  wire logic [N_EDGE-1:0]                    edge_wake_clear,
  input  wire logic [N_EDGE-1:0]                    edge_mgmt_clear,
  input  wire logic [N_EDGE-1:0]                    edge_group_clear,
  input  wire logic [N_EDGE-1:0]                    misc_clear,
  output logic      [N_EDGE-1:0]                    edge_data_status,
  output logic      [N_EDGE-1:0]                    edge_wake_status,
  output logic      [N_EDGE-1:0]                    edge_mgmt_status,
  output logic      [N_EDGE-1:0]                    wake_status_reg_group,
  output logic      [N_EDGE-1:0]                    misc_edge_status_reg,
  output logic                                      edge_wake_request,
  // Single-edge GPIO and tachometer events
  input  wire logic [N_GP-1:0]                      gp_event_in,
  input  wire logic [N_GP-1:0]                      gp_polarity,
  input  wire logic [N_GP-1:0]                      gp_mgmt_enable,
  input  wire logic [N_GP-1:0]                      gp_mgmt_clear,
  output logic      [N_GP-1:0]                      gp_mgmt_status,
  // Peripheral events
  input  wire logic [mgmt_irq_pkg::PERIPH_COUNT-1:0] periph_event,
  input  wire logic [mgmt_irq_pkg::PERIPH_COUNT-1:0] periph_enable,
  input  wire logic                                 status2_read,
  output logic      [mgmt_irq_pkg::PERIPH_COUNT-1:0] mgmt_irq_status_reg_second,
  // Routing and shared pin control
  input  wire logic [7:0]                           mgmt_enable_second,
  input  wire logic                                 shared_pin_irq_select,
  input  wire logic                                 pin_ctrl_write,
  input  wire logic [7:0]                           pin_ctrl_wdata,
  output logic      [7:0]                           pin_ctrl_reg,
  input  wire logic                                 device_irq_wake_enable,
  output logic                                      group_mgmt_irq_internal,
  output logic                                      group_mgmt_irq_pin_out,
  output logic                                      group_mgmt_irq_pin_oe,
  output logic                                      serial_irq2_request,
  // Status and enable bits are ports; the runtime block decodes their offsets
  output logic      [7:0]                           wake_status_reg_third, // RULE22
  output logic                                      device_irq_wake_request
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (N_EDGE < 1 || N_EDGE > 32) begin : g_bad_edge
    $error("N_EDGE out of range");
  end
  if (N_GP < 1 || N_GP > 32) begin : g_bad_gp
    $error("N_GP out of range");
  end

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  edge_evt_if #(.W(N_EDGE)) ev_e ();
  edge_evt_if #(.W(N_GP))   ev_g ();

  edge_sampler #(.W(N_EDGE)) u_edge_samp (
    .clk    (clk),
    .rst    (rst),
    .raw_in (edge_pin_in),
    .ev     (ev_e.src)
  );

  edge_sampler #(.W(N_GP)) u_gp_samp (
    .clk    (clk),
    .rst    (rst),
    .raw_in (gp_event_in),
    .ev     (ev_g.src)
  );

  // ----------------------------------------------------------------
  // Dual-edge pin status
  // ----------------------------------------------------------------
  logic [N_EDGE-1:0] edge_any;
  logic [N_EDGE-1:0] edge_pol_hit;
  logic [N_EDGE-1:0] edge_irq_set;

  // Only polarity chooses the edge when dual-edge is off
  assign edge_any     = ev_e.rise | ev_e.fall; // RULE1
  assign edge_pol_hit = (ev_e.rise & ~edge_polarity) | (ev_e.fall & edge_polarity);
  assign edge_irq_set = (dual_edge_trigger & edge_any)
                      | (~dual_edge_trigger & edge_pol_hit); // RULE17 RULE2

  sticky_w1c #(.W(N_EDGE)) u_edge_wake (
    .clk    (clk),
    .rst    (rst),
    .set    (edge_irq_set), // RULE5 RULE8
    .clr    (edge_wake_clear),
    .status (edge_wake_status)
  );

  sticky_w1c #(.W(N_EDGE)) u_edge_mgmt (
    .clk    (clk),
    .rst    (rst),
    .set    (edge_irq_set), // RULE5 RULE8
    .clr    (edge_mgmt_clear),
    .status (edge_mgmt_status)
  );

  sticky_w1c #(.W(N_EDGE)) u_edge_group (
    .clk    (clk),
    .rst    (rst),
    .set    (edge_any), // RULE6 RULE8
    .clr    (edge_group_clear),
    .status (wake_status_reg_group)
  );

  sticky_w1c #(.W(N_EDGE)) u_misc (
    .clk    (clk),
    .rst    (rst),
    .set    (edge_any), // RULE7 RULE8
    .clr    (misc_clear),
    .status (misc_edge_status_reg)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_data_status <= '0;
    end else begin
      edge_data_status <= ev_e.level ^ edge_polarity; // RULE3
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_wake_request <= 1'b0;
    end else begin
      edge_wake_request <= |(edge_wake_status & edge_wake_enable & dual_edge_trigger); // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Single-edge GPIO and tachometer status
  // ----------------------------------------------------------------
  logic [N_GP-1:0] gp_set;

  assign gp_set = (ev_g.rise & ~gp_polarity) | (ev_g.fall & gp_polarity); // RULE16

  sticky_w1c #(.W(N_GP)) u_gp_mgmt (
    .clk    (clk),
    .rst    (rst),
    .set    (gp_set),
    .clr    (gp_mgmt_clear), // RULE17
    .status (gp_mgmt_status)
  );

  // ----------------------------------------------------------------
  // Peripheral status
  // ----------------------------------------------------------------
  logic                                 ir_status;
  logic [mgmt_irq_pkg::PERIPH_COUNT-1:0] periph_view;

  // Infrared is the only latched peripheral flag
  sticky_w1c #(.W(1)) u_ir (
    .clk    (clk),
    .rst    (rst),
    .set    (periph_event[mgmt_irq_pkg::PERIPH_INFRARED]),
    .clr    (status2_read), // RULE20
    .status (ir_status)
  );

  always_comb begin
    periph_view = periph_event; // RULE19
    periph_view[mgmt_irq_pkg::PERIPH_INFRARED] = ir_status;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mgmt_irq_status_reg_second <= '0;
    end else begin
      mgmt_irq_status_reg_second <= periph_view; // RULE19
    end
  end

  // ----------------------------------------------------------------
  // Group interrupt
  // ----------------------------------------------------------------
  logic group_next;

  assign group_next = |(periph_view & periph_enable) // RULE21 RULE15
                    | |(gp_mgmt_status & gp_mgmt_enable) // RULE18
                    | |(edge_mgmt_status & edge_mgmt_enable & dual_edge_trigger); // RULE11 RULE4

  always_ff @(posedge clk) begin
    if (rst) begin
      group_mgmt_irq_internal <= 1'b0;
    end else begin
      group_mgmt_irq_internal <= group_next; // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Shared pin control byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ctrl_reg <= mgmt_irq_pkg::PIN_CTRL_RESET; // RULE10
    end else if (pin_ctrl_write) begin
      pin_ctrl_reg <= pin_ctrl_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Routing to pin, serial IRQ2 and wake logic
  // ----------------------------------------------------------------
  logic pin_assert;
  logic pin_active_high;
  logic pin_push_pull;

  assign pin_assert      = group_mgmt_irq_internal
                         & mgmt_enable_second[mgmt_irq_pkg::EN2_PIN_ROUTE]; // RULE12
  assign pin_active_high = pin_ctrl_reg[mgmt_irq_pkg::PIN_CTRL_POLARITY];
  assign pin_push_pull   = pin_ctrl_reg[mgmt_irq_pkg::PIN_CTRL_DRIVER];

  always_ff @(posedge clk) begin
    if (rst) begin
      group_mgmt_irq_pin_out <= 1'b0;
      group_mgmt_irq_pin_oe  <= 1'b0;
    end else begin
      // Wire level: asserted matches the programmed active level
      group_mgmt_irq_pin_out <= pin_assert ~^ pin_active_high; // RULE9
      // Open drain only drives the low level
      group_mgmt_irq_pin_oe  <= shared_pin_irq_select
                              & (pin_push_pull | ~(pin_assert ~^ pin_active_high)); // RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_irq2_request <= 1'b0;
    end else begin
      serial_irq2_request <= group_mgmt_irq_internal
                           & mgmt_enable_second[mgmt_irq_pkg::EN2_SERIAL_ROUTE]; // RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_status_reg_third   <= '0;
      device_irq_wake_request <= 1'b0;
    end else begin
      wake_status_reg_third <= '0;
      wake_status_reg_third[mgmt_irq_pkg::WAKE3_DEVINT] <= group_mgmt_irq_internal
        & mgmt_enable_second[mgmt_irq_pkg::EN2_WAKE_ROUTE]; // RULE14 RULE23
      device_irq_wake_request <= wake_status_reg_third[mgmt_irq_pkg::WAKE3_DEVINT]
                               & device_irq_wake_enable; // RULE24
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MISC_ANY_EDGE: assert property ((ev_e.rise[0] | ev_e.fall[0]) |=> misc_edge_status_reg[0]) // RULE7
    else $error("misc status missed an edge");
  AST_DUAL_FALL: assert property (dual_edge_trigger[0] && ev_e.fall[0] |=> edge_mgmt_status[0]) // RULE17
    else $error("dual-edge fall did not set status");
  AST_POL_RISE: assert property (!gp_polarity[0] && ev_g.rise[0] |=> gp_mgmt_status[0]) // RULE16
    else $error("rising gpio edge not latched");
  AST_STICKY_HOLD: assert property (edge_wake_status[0] && !edge_wake_clear[0] && !edge_irq_set[0]
    |=> edge_wake_status[0]) // RULE5
    else $error("sticky wake status lost");
  AST_DATA_POL: assert property (edge_data_status[0] == $past(ev_e.level[0] ^ edge_polarity[0])) // RULE3
    else $error("data status ignores polarity");
  AST_SERIAL_ROUTE: assert property (serial_irq2_request
    |-> $past(mgmt_enable_second[mgmt_irq_pkg::EN2_SERIAL_ROUTE])) // RULE13
    else $error("serial request without route enable");
  AST_IR_CLEAR: assert property (status2_read && ir_status
    && !periph_event[mgmt_irq_pkg::PERIPH_INFRARED] |=> !ir_status) // RULE20
    else $error("infrared status survived read");
  AST_PERIPH_LIVE: assert property (mgmt_irq_status_reg_second[mgmt_irq_pkg::PERIPH_PARPORT]
    == $past(periph_event[mgmt_irq_pkg::PERIPH_PARPORT])) // RULE19
    else $error("peripheral status not following source");
  AST_PIN_GATE: assert property (!mgmt_enable_second[mgmt_irq_pkg::EN2_PIN_ROUTE] && !pin_push_pull
    && !pin_active_high && !pin_ctrl_write |=> !group_mgmt_irq_pin_oe) // RULE12
    else $error("pin driven while route disabled");
  AST_DEVINT_PATH: assert property (group_mgmt_irq_internal
    && mgmt_enable_second[mgmt_irq_pkg::EN2_WAKE_ROUTE] && device_irq_wake_enable
    ##1 device_irq_wake_enable |=> device_irq_wake_request) // RULE14
    else $error("device interrupt wake not raised");

  COV_DUAL_EDGE_IRQ: cover property (dual_edge_trigger[0] && ev_e.fall[0] ##2 group_mgmt_irq_internal);
  COV_IR_READ: cover property (ir_status ##1 status2_read ##1 !ir_status);
  COV_PIN_ASSERT: cover property (group_mgmt_irq_pin_oe && !group_mgmt_irq_pin_out);

endmodule : mgmt_irq_aggregator
`default_nettype wire

/* mgmt_irq_pkg.sv */
// Purpose: Shared constants for the management interrupt aggregator
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bit positions of the enable-2 byte and pin control byte
package mgmt_irq_pkg;

  // ----------------------------------------------------------------
  // Default sizes
  // ----------------------------------------------------------------
  localparam int EDGE_PINS_DEFAULT = 3;
  localparam int GP_EVENTS_DEFAULT = 8;

  // ----------------------------------------------------------------
  // Peripheral event positions in the second status group
  // ----------------------------------------------------------------
  localparam int PERIPH_PARPORT  = 0;
  localparam int PERIPH_SERIAL1  = 1;
  localparam int PERIPH_SERIAL2  = 2;
  localparam int PERIPH_FLOPPY   = 3;
  localparam int PERIPH_INFRARED = 4;
  localparam int PERIPH_AUXMOUSE = 5;
  localparam int PERIPH_SPECMSE  = 6;
  localparam int PERIPH_COUNT    = 7;

  // ----------------------------------------------------------------
  // Second enable register routing bits
  // ----------------------------------------------------------------
  localparam int EN2_PIN_ROUTE    = 7;
  localparam int EN2_SERIAL_ROUTE = 6;
  localparam int EN2_WAKE_ROUTE   = 5;

  // ----------------------------------------------------------------
  // Shared pin control byte
  // ----------------------------------------------------------------
  localparam int PIN_CTRL_POLARITY = 1;
  localparam int PIN_CTRL_DRIVER   = 7;
  // Polarity 0 = active low, driver 0 = open drain
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Third wake status / enable registers
  // ----------------------------------------------------------------
  localparam int WAKE3_DEVINT = 3;

endpackage : mgmt_irq_pkg

/* sticky_w1c.sv */
// Purpose: Vector of sticky status flags, set by hardware, write-one clear
// Assumes: set and clr are one-cycle pulses per bit
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module sticky_w1c #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] status
);

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= set | (status & ~clr);
    end
  end

endmodule : sticky_w1c
`default_nettype wire
